/* ueh_host_model.sv */
`timescale 1ns/1ns
module ueh_host_model
  import ueh_pkg::*;
(
  // Clock
  input wire logic clk,
  // Engine answers
  input wire logic [2:0] resp,
  input wire logic resp_valid,
  input wire logic ep_irq,
  // Packet layer reports
  output ueh_txn_t txn,
  output logic data_phase,
  output logic bus_event
);
  // ***********************************************
  // Host side of the upstream port
  // ***********************************************
  initial begin
    txn = '0;
    data_phase = 1'b0;
    bus_event = 1'b0;
  end

  // Non-idle line event
  task automatic activity();
    @(posedge clk);
    bus_event <= 1'b1;
    @(posedge clk);
    bus_event <= 1'b0;
  endtask : activity

  // One transaction; the answer window is fixed by the engine timing
  task automatic send(input ueh_tok_t tok, input logic [5:0] cnt,
    input logic crc, input logic tog, input logic hack,
    output logic [2:0] r, output logic irq);
    r = UEH_R_NONE;
    irq = 1'b0;
    if (tok == UEH_TK_SETUP) begin
      @(posedge clk);
      data_phase <= 1'b1;
      @(posedge clk);
      data_phase <= 1'b0;
    end
    @(posedge clk);
    txn <= '{1'b1, tok, cnt, crc, tog, hack};
    @(posedge clk);
    // Stale fields scrambled so the engine cannot lean on them
    txn <= '{1'b0, tok, ~cnt, ~crc, ~tog, ~hack};
    repeat (6) begin
      @(negedge clk);
      if (resp_valid === 1'b1) begin
        r = resp;
      end
      if (ep_irq === 1'b1) begin
        irq = 1'b1;
      end
    end
  endtask : send
endmodule : ueh_host_model

/* ueh_pkg.sv */
package ueh_pkg;
  // ***********************************************
  // Register map
  // ***********************************************
  localparam logic [3:0] UEH_ADDR_USC = 4'h0;
  localparam logic [3:0] UEH_ADDR_CNT = 4'h1;
  localparam logic [3:0] UEH_ADDR_MODE = 4'h2;
  localparam logic [3:0] UEH_ADDR_IRQ = 4'h3;
  localparam logic [7:0] UEH_USC_RST = 8'h00;
  localparam logic [7:0] UEH_CNT_RST = 8'h00;
  localparam logic [7:0] UEH_MODE_RST = 8'h00;
  localparam int UEH_BIT_ACT = 3;
  localparam int UEH_BIT_DM = 4;
  localparam int UEH_BIT_DP = 5;
  localparam int UEH_BIT_SETUP = 7;
  localparam int UEH_BIT_IN = 6;
  localparam int UEH_BIT_OUT = 5;
  localparam int UEH_BIT_ACK = 4;
  localparam int UEH_BIT_TOG = 7;
  localparam int UEH_BIT_DVAL = 6;
  localparam logic [4:0] UEH_EP_SIZE = 5'h08;
  localparam logic [5:0] UEH_CRC_BYTES = 6'h02;
  localparam logic [5:0] UEH_STATUS_LEN = 6'h02;

  // ***********************************************
  // Endpoint modes
  // ***********************************************
  localparam logic [3:0] UEH_M_DIS = 4'h0;
  localparam logic [3:0] UEH_M_NAKALL = 4'h1;
  localparam logic [3:0] UEH_M_STATOUT = 4'h2;
  localparam logic [3:0] UEH_M_STALLALL = 4'h3;
  localparam logic [3:0] UEH_M_ISOOUT = 4'h5;
  localparam logic [3:0] UEH_M_ISOIN = 4'h7;
  localparam logic [3:0] UEH_M_NAKOUT = 4'h8;
  localparam logic [3:0] UEH_M_OUT = 4'h9;
  localparam logic [3:0] UEH_M_NAKIN = 4'hC;
  localparam logic [3:0] UEH_M_IN = 4'hD;
  localparam logic [3:0] UEH_M_NAKIN_ST = 4'hE;
  localparam logic [3:0] UEH_M_IN_ST = 4'hF;

  typedef enum logic [1:0] {
    UEH_TK_SETUP = 2'h0,
    UEH_TK_IN = 2'h1,
    UEH_TK_OUT = 2'h2
  } ueh_tok_t;

  typedef enum logic [2:0] {
    UEH_R_NONE = 3'h0,
    UEH_R_ACK = 3'h1,
    UEH_R_NAK = 3'h2,
    UEH_R_STALL = 3'h3,
    UEH_R_DATA = 3'h4
  } ueh_resp_t;

  // Transaction report from the packet layer
  typedef struct packed {
    logic valid;
    ueh_tok_t tok;
    logic [5:0] count;
    logic crc_ok;
    logic tog;
    logic host_ack;
  } ueh_txn_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ueh_bus_t;

  typedef enum logic [2:0] {
    UEH_S_IDLE = 3'b001,
    UEH_S_DECIDE = 3'b010,
    UEH_S_UPDATE = 3'b100
  } ueh_state_t;
endpackage : ueh_pkg

/* ueh_sie.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - Codes 000-011 select engine or forced levels
// - Codes 100-111 force low or float lines
// - Engine sets sticky bus activity bit 3
// - Writing 0 clears activity, 1 keeps
// - Bits 4,5 show live minus, plus
// - Setup bit held until data phase ends
// - Acked transaction locks mode, count until read
// - Update refreshes mode, count, sets interrupt
// - Accepted SETUP is acked, mode becomes 0001
// - Acked modes fall to NAK, except 0010/0101/1110, and 1111 acked on IN
// - Mode 1111 becomes 1110 after status OUT
// - Endpoints reset disabled, stay until rewritten
// - Only valid transactions answered, then interrupt
// - Bad CRC SETUP interrupts unless disabled, bad CRC OUT only in 0001/0011/0101/1001
// - Valid data count at most size plus 2
// - OUT endpoint ignores IN, and reverse
// - IN/OUT bits at end, setup at data
// - Normal OUT stores, acks, goes NAK-OUT
// - NAK-OUT naks, sets OUT bit, interrupts
// - Normal IN sends data, host ack goes NAK-IN
// - Status OUT needs 2 bytes toggle 1, else stall
module ueh_sie
  import ueh_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Packet layer
  input wire logic TXN_VALID,
  input wire logic [1:0] TXN_TOK,
  input wire logic [5:0] TXN_COUNT,
  input wire logic TXN_CRC_OK,
  input wire logic TXN_TOG,
  input wire logic TXN_HOST_ACK,
  input wire logic DATA_PHASE,
  input wire logic BUS_EVENT,
  output logic [2:0] RESP,
  output logic RESP_VALID,
  output logic EP_IRQ,
  // Upstream pins
  input wire logic DP_IN,
  input wire logic DM_IN,
  input wire logic SIE_DP,
  input wire logic SIE_DM,
  input wire logic SIE_OE_N,
  output logic DP_OUT,
  output logic DM_OUT,
  output logic DP_OE_N,
  output logic DM_OE_N
);
  // ***********************************************
  // Reset release
  // ***********************************************
  logic rst_a_r;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_a_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n <= rst_a_r;
    end
  end

  ueh_txn_t txn;
  ueh_bus_t bus;
  assign txn = '{TXN_VALID, ueh_tok_t'(TXN_TOK), TXN_COUNT, TXN_CRC_OK,
                 TXN_TOG, TXN_HOST_ACK};
  assign bus = '{ADDR, WDATA, WR, RD};

  // ***********************************************
  // Registers
  // ***********************************************
  logic [7:0] usc_r, usc_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic lock_r, lock_nxt;
  logic setup_hold_r, setup_hold_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] resp_r, resp_nxt;
  logic resp_v_r, resp_v_nxt;
  ueh_state_t st_r, st_nxt;
  ueh_txn_t t_r, t_nxt;

  // Decision outputs
  logic [3:0] m;
  logic cnt_ok;
  logic upd;
  logic [3:0] new_mode;
  logic [7:0] new_cnt;
  logic [2:0] rsp;
  logic set_in, set_out, set_ack, do_irq, acked;

  assign m = mode_r[3:0];
  // Size limit includes the two CRC bytes
  assign cnt_ok = (t_r.count <= ({1'b0, UEH_EP_SIZE} + UEH_CRC_BYTES));

  always_comb begin
    upd = 1'b0;
    new_mode = m;
    new_cnt = cnt_r;
    rsp = UEH_R_NONE;
    set_in = 1'b0;
    set_out = 1'b0;
    set_ack = 1'b0;
    do_irq = 1'b0;
    if (t_r.tok == UEH_TK_SETUP) begin
      if (t_r.crc_ok && cnt_ok && m inside {UEH_M_STATOUT, UEH_M_STALLALL,
          UEH_M_NAKALL, UEH_M_NAKIN_ST, UEH_M_IN_ST}) begin
        rsp = UEH_R_ACK;
        new_mode = UEH_M_NAKALL;
        new_cnt = {t_r.tog, 1'b1, t_r.count};
        set_ack = 1'b1;
        upd = 1'b1;
        do_irq = 1'b1;
      end else if (!t_r.crc_ok && m != UEH_M_DIS) begin
        do_irq = 1'b1;
      end
    end else if (t_r.tok == UEH_TK_OUT) begin
      case (m)
        UEH_M_OUT: begin
          if (t_r.crc_ok && cnt_ok) begin
            rsp = UEH_R_ACK;
            new_mode = UEH_M_NAKOUT;
            new_cnt = {t_r.tog, 1'b1, t_r.count};
            set_out = 1'b1;
            set_ack = 1'b1;
          end else begin
            // Buffer is junk: data-valid reflects the failure
            new_cnt = {t_r.tog, 1'b0, t_r.count};
            set_out = 1'b1;
          end
          upd = 1'b1;
          do_irq = 1'b1;
        end
        UEH_M_NAKOUT: begin
          if (t_r.crc_ok && cnt_ok) begin
            rsp = UEH_R_NAK;
            set_out = 1'b1;
            upd = 1'b1;
            do_irq = 1'b1;
          end
        end
        UEH_M_ISOOUT: begin
          // No handshake on isochronous traffic
          new_cnt = {t_r.tog, t_r.crc_ok & cnt_ok, t_r.count};
          set_out = 1'b1;
          set_ack = 1'b1;
          upd = 1'b1;
          do_irq = 1'b1;
        end
        UEH_M_STATOUT, UEH_M_NAKIN_ST, UEH_M_IN_ST: begin
          if (t_r.crc_ok && cnt_ok) begin
            upd = 1'b1;
            do_irq = 1'b1;
            set_out = 1'b1;
            new_cnt = {t_r.tog, 1'b1, t_r.count};
            if (t_r.count == UEH_STATUS_LEN && t_r.tog) begin
              rsp = UEH_R_ACK;
              set_ack = 1'b1;
              if (m == UEH_M_IN_ST) new_mode = UEH_M_NAKIN_ST;
            end else begin
              rsp = UEH_R_STALL;
              new_mode = UEH_M_STALLALL;
            end
          end
        end
        UEH_M_STALLALL: begin
          rsp = UEH_R_STALL;
          upd = 1'b1;
          set_out = 1'b1;
          do_irq = 1'b1;
        end
        UEH_M_NAKALL: begin
          rsp = UEH_R_NAK;
          upd = 1'b1;
          set_out = 1'b1;
          do_irq = 1'b1;
        end
        // IN-only and disabled modes ignore OUT
        default: upd = 1'b0;
      endcase
    end else if (t_r.tok == UEH_TK_IN) begin
      case (m)
        UEH_M_IN, UEH_M_IN_ST: begin
          rsp = UEH_R_DATA;
          if (t_r.host_ack) begin
            new_mode = (m == UEH_M_IN) ? UEH_M_NAKIN : m;
            set_in = 1'b1;
            set_ack = 1'b1;
            upd = 1'b1;
            do_irq = 1'b1;
          end
        end
        UEH_M_ISOIN: begin
          rsp = UEH_R_DATA;
          set_in = 1'b1;
          upd = 1'b1;
          do_irq = 1'b1;
        end
        UEH_M_NAKIN, UEH_M_NAKIN_ST, UEH_M_NAKALL: begin
          rsp = UEH_R_NAK;
          set_in = 1'b1;
          upd = 1'b1;
          do_irq = 1'b1;
        end
        UEH_M_STATOUT, UEH_M_STALLALL: begin
          rsp = UEH_R_STALL;
          new_mode = UEH_M_STALLALL;
          set_in = 1'b1;
          upd = 1'b1;
          do_irq = 1'b1;
        end
        // OUT-only and disabled modes ignore IN
        default: upd = 1'b0;
      endcase
    end
  end

  assign acked = upd && set_ack;

  // ***********************************************
  // Sequencer and register updates
  // ***********************************************
  always_comb begin
    st_nxt = st_r;
    t_nxt = t_r;
    usc_nxt = usc_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    lock_nxt = lock_r;
    setup_hold_nxt = setup_hold_r;
    irq_nxt = 1'b0;
    resp_nxt = resp_r;
    resp_v_nxt = 1'b0;
    rdata_nxt = 8'h00;
    // Firmware access first, so engine updates override it
    if (bus.rd) begin
      case (bus.addr)
        UEH_ADDR_USC: rdata_nxt = {usc_r[7:6], DP_IN, DM_IN, usc_r[3:0]};
        UEH_ADDR_CNT: rdata_nxt = cnt_r;
        UEH_ADDR_MODE: rdata_nxt = mode_r;
        default: rdata_nxt = 8'h00;
      endcase
      // A read after the update releases the lock
      if (st_r != UEH_S_UPDATE && bus.addr inside {UEH_ADDR_CNT, UEH_ADDR_MODE})
        lock_nxt = 1'b0;
    end
    if (bus.wr) begin
      case (bus.addr)
        UEH_ADDR_USC: begin
          usc_nxt[7:6] = bus.wdata[7:6];
          usc_nxt[2:0] = bus.wdata[2:0];
          usc_nxt[UEH_BIT_ACT] = usc_r[UEH_BIT_ACT] & bus.wdata[UEH_BIT_ACT];
        end
        UEH_ADDR_MODE: begin
          if (!setup_hold_r) mode_nxt[UEH_BIT_SETUP] = bus.wdata[UEH_BIT_SETUP];
          if (!lock_r) mode_nxt[6:0] = bus.wdata[6:0];
        end
        UEH_ADDR_CNT: begin
          if (!lock_r) cnt_nxt = bus.wdata;
        end
        default: usc_nxt = usc_nxt;
      endcase
    end
    if (BUS_EVENT) usc_nxt[UEH_BIT_ACT] = 1'b1;
    // Setup bit forced at the data phase of a SETUP
    if (DATA_PHASE && t_r.tok == UEH_TK_SETUP && st_r == UEH_S_IDLE) begin
      mode_nxt[UEH_BIT_SETUP] = 1'b1;
      setup_hold_nxt = 1'b1;
    end
    case (st_r)
      UEH_S_IDLE: begin
        if (txn.valid) begin
          t_nxt = txn;
          st_nxt = UEH_S_DECIDE;
          if (txn.tok == UEH_TK_SETUP && txn.crc_ok) begin
            mode_nxt[UEH_BIT_SETUP] = 1'b1;
            setup_hold_nxt = 1'b1;
          end
        end
      end
      UEH_S_DECIDE: begin
        resp_nxt = rsp;
        resp_v_nxt = (rsp != UEH_R_NONE);
        st_nxt = UEH_S_UPDATE;
      end
      UEH_S_UPDATE: begin
        if (upd) begin
          mode_nxt[3:0] = new_mode;
          mode_nxt[UEH_BIT_IN] = set_in | mode_r[UEH_BIT_IN];
          mode_nxt[UEH_BIT_OUT] = set_out | mode_r[UEH_BIT_OUT];
          mode_nxt[UEH_BIT_ACK] = set_ack;
          cnt_nxt = new_cnt;
        end
        if (acked) lock_nxt = 1'b1;
        // Data phase of the control write is over
        if (t_r.tok == UEH_TK_OUT) setup_hold_nxt = 1'b0;
        irq_nxt = do_irq;
        st_nxt = UEH_S_IDLE;
      end
      default: st_nxt = UEH_S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= UEH_S_IDLE;
      t_r <= '0;
      usc_r <= UEH_USC_RST;
      mode_r <= UEH_MODE_RST;
      cnt_r <= UEH_CNT_RST;
      lock_r <= 1'b0;
      setup_hold_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      resp_r <= UEH_R_NONE;
      resp_v_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      t_r <= t_nxt;
      usc_r <= usc_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      lock_r <= lock_nxt;
      setup_hold_r <= setup_hold_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
      resp_v_r <= resp_v_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign RESP = resp_r;
  assign RESP_VALID = resp_v_r;
  assign EP_IRQ = irq_r;

  // ***********************************************
  // Upstream driver override
  // ***********************************************
  always_comb begin
    DP_OUT = SIE_DP;
    DM_OUT = SIE_DM;
    DP_OE_N = SIE_OE_N;
    DM_OE_N = SIE_OE_N;
    case (usc_r[2:0])
      3'h0: DP_OE_N = SIE_OE_N;
      3'h1: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h8;
      3'h2: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h4;
      3'h3: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h0;
      3'h4: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h0;
      3'h5: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h2;
      3'h6: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h1;
      default: {DP_OUT, DM_OUT, DP_OE_N, DM_OE_N} = 4'h3;
    endcase
  end

  // ***********************************************
  // Checks
  // ***********************************************
  property p_act_set;
    @(posedge CLK) disable iff (!rst_n) BUS_EVENT |=> usc_r[UEH_BIT_ACT];
  endproperty
  a_act_set: assert property (p_act_set) else $error("activity not set");
  property p_act_clr;
    @(posedge CLK) disable iff (!rst_n)
      (bus.wr && bus.addr == UEH_ADDR_USC && !bus.wdata[UEH_BIT_ACT] && !BUS_EVENT)
      |=> !usc_r[UEH_BIT_ACT];
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("activity not cleared");
  property p_force_hi;
    @(posedge CLK) disable iff (!rst_n)
      usc_r[2:0] == 3'h1 |-> DP_OUT && !DM_OUT && !DP_OE_N && !DM_OE_N;
  endproperty
  a_force_hi: assert property (p_force_hi) else $error("force J wrong");
  property p_float;
    @(posedge CLK) disable iff (!rst_n) usc_r[2:0] == 3'h7 |-> DP_OE_N && DM_OE_N;
  endproperty
  a_float: assert property (p_float) else $error("float wrong");
  property p_lock;
    @(posedge CLK) disable iff (!rst_n)
      (lock_r && bus.wr && bus.addr == UEH_ADDR_CNT && st_r == UEH_S_IDLE && !txn.valid)
      |=> $stable(cnt_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked count written");
  property p_setup_hold;
    @(posedge CLK) disable iff (!rst_n)
      setup_hold_r |=> mode_r[UEH_BIT_SETUP];
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup bit dropped");
  property p_setup_mode;
    @(posedge CLK) disable iff (!rst_n)
      (st_r == UEH_S_UPDATE && upd && t_r.tok == UEH_TK_SETUP)
      |=> mode_r[3:0] == UEH_M_NAKALL;
  endproperty
  a_setup_mode: assert property (p_setup_mode) else $error("setup mode wrong");
  property p_irq;
    @(posedge CLK) disable iff (!rst_n)
      EP_IRQ |-> $past(st_r) == UEH_S_UPDATE;
  endproperty
  a_irq: assert property (p_irq) else $error("stray interrupt");
endmodule : ueh_sie

/* ueh_sie_tb_top.sv */
`timescale 1ns/1ns
module ueh_sie_tb_top
  import ueh_pkg::*;
;
  // Pin levels per control code: plus, minus, plus oe_n, minus oe_n
  localparam logic [31:0] PIN_TAB = 32'hB1A00484;
  logic clk;
  logic reset_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  ueh_txn_t txn;
  logic data_phase;
  logic bus_event;
  logic [2:0] resp;
  logic resp_valid;
  logic ep_irq;
  logic sie_dp;
  logic sie_dm;
  logic sie_oe_n;
  logic dp_out;
  logic dm_out;
  logic dp_oe_n;
  logic dm_oe_n;
  logic dp_lvl;
  logic dm_lvl;
  logic [7:0] v;
  logic [3:0] e;
  logic [2:0] r;
  logic irq;
  int fails;
  int checks;

  // Pull-up on plus, pull-down on minus when floated
  assign dp_lvl = dp_oe_n ? 1'b1 : dp_out;
  assign dm_lvl = dm_oe_n ? 1'b0 : dm_out;

  ueh_sie ueh_sie_i (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TXN_VALID(txn.valid), .TXN_TOK(txn.tok), .TXN_COUNT(txn.count),
    .TXN_CRC_OK(txn.crc_ok), .TXN_TOG(txn.tog),
    .TXN_HOST_ACK(txn.host_ack), .DATA_PHASE(data_phase),
    .BUS_EVENT(bus_event), .RESP(resp), .RESP_VALID(resp_valid),
    .EP_IRQ(ep_irq), .DP_IN(dp_lvl), .DM_IN(dm_lvl), .SIE_DP(sie_dp),
    .SIE_DM(sie_dm), .SIE_OE_N(sie_oe_n), .DP_OUT(dp_out),
    .DM_OUT(dm_out), .DP_OE_N(dp_oe_n), .DM_OE_N(dm_oe_n));

  ueh_host_model ueh_host_model_i (.clk(clk), .resp(resp),
    .resp_valid(resp_valid), .ep_irq(ep_irq), .txn(txn),
    .data_phase(data_phase), .bus_event(bus_event));

  // ***********************************************
  // Bench tasks
  // ***********************************************
  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd

  // Unlock, set mode, run one transaction, judge answer and mode byte
  task automatic txn_case(input logic [3:0] m, input ueh_tok_t tok,
    input logic [5:0] cnt, input logic [2:0] fl, input logic [7:0] em,
    input ueh_resp_t er, input logic ei);
    logic [7:0] d;
    logic [2:0] rr;
    logic ii;
    reg_rd(UEH_ADDR_MODE, d);
    reg_wr(UEH_ADDR_MODE, {4'h0, m});
    ueh_host_model_i.send(tok, cnt, fl[2], fl[1], fl[0], rr, ii);
    check("resp", {5'h00, rr}, {5'h00, er});
    check("irq", {7'h00, ii}, {7'h00, ei});
    reg_rd(UEH_ADDR_MODE, d);
    check("mode", d, em);
  endtask : txn_case

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // ***********************************************
  // Clock, watchdog and test sequence
  // ***********************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    sie_dp = 1'b0;
    sie_dm = 1'b1;
    sie_oe_n = 1'b0;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(UEH_ADDR_MODE, v);
    check("mode_rst", v, UEH_MODE_RST);
    reg_rd(UEH_ADDR_CNT, v);
    check("cnt_rst", v, UEH_CNT_RST);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      reg_wr(UEH_ADDR_USC, 8'(c));
      reg_rd(UEH_ADDR_USC, v);
      e = PIN_TAB[4*c +: 4];
      check("pins", {4'h0, dp_lvl, dm_lvl, dp_oe_n, dm_oe_n},
        {4'h0, e});
      check("usc", v, {2'b00, e[3], e[2], 1'b0, 3'(c)});
    end
    reg_wr(UEH_ADDR_USC, 8'h00);
    $display("test pins done");
    ueh_host_model_i.activity();
    reg_rd(UEH_ADDR_USC, v);
    check("act_set", {7'h00, v[3]}, 8'h01);
    reg_wr(UEH_ADDR_USC, 8'h08);
    reg_rd(UEH_ADDR_USC, v);
    check("act_keep", {7'h00, v[3]}, 8'h01);
    reg_wr(UEH_ADDR_USC, 8'h00);
    reg_rd(UEH_ADDR_USC, v);
    check("act_clr", {7'h00, v[3]}, 8'h00);
    reg_wr(UEH_ADDR_USC, 8'h08);
    reg_rd(UEH_ADDR_USC, v);
    check("act_fw", {7'h00, v[3]}, 8'h00);
    $display("test activity done");
    reg_wr(UEH_ADDR_MODE, {4'h0, UEH_M_OUT});
    ueh_host_model_i.send(UEH_TK_OUT, 6'h0A, 1'b1, 1'b1, 1'b0, r, irq);
    check("out_resp", {5'h00, r}, {5'h00, UEH_R_ACK});
    check("out_irq", {7'h00, irq}, 8'h01);
    reg_wr(UEH_ADDR_CNT, 8'h00);
    reg_wr(UEH_ADDR_MODE, 8'h0D);
    reg_rd(UEH_ADDR_MODE, v);
    check("lock_mode", v, 8'h38);
    reg_rd(UEH_ADDR_CNT, v);
    check("lock_cnt", {6'h00, v[7:6]}, 8'h03);
    reg_wr(UEH_ADDR_MODE, 8'h0D);
    reg_rd(UEH_ADDR_MODE, v);
    check("unlock", v, 8'h0D);
    $display("test lock done");
    txn_case(UEH_M_DIS, UEH_TK_OUT, 6'h0A, 3'h6,
      8'h00, UEH_R_NONE, 1'b0);
    txn_case(UEH_M_NAKOUT, UEH_TK_OUT, 6'h0A, 3'h6,
      8'h28, UEH_R_NAK, 1'b1);
    txn_case(UEH_M_NAKOUT, UEH_TK_OUT, 6'h0B, 3'h6,
      8'h08, UEH_R_NONE, 1'b0);
    txn_case(UEH_M_OUT, UEH_TK_OUT, 6'h0A, 3'h2,
      8'h29, UEH_R_NONE, 1'b1);
    txn_case(UEH_M_OUT, UEH_TK_IN, 6'h00, 3'h7,
      8'h09, UEH_R_NONE, 1'b0);
    txn_case(UEH_M_ISOOUT, UEH_TK_OUT, 6'h0A, 3'h6,
      8'h35, UEH_R_NONE, 1'b1);
    txn_case(UEH_M_ISOOUT, UEH_TK_IN, 6'h00, 3'h7,
      8'h05, UEH_R_NONE, 1'b0);
    txn_case(UEH_M_IN, UEH_TK_IN, 6'h00, 3'h7,
      8'h5C, UEH_R_DATA, 1'b1);
    txn_case(UEH_M_IN, UEH_TK_OUT, 6'h02, 3'h6,
      8'h0D, UEH_R_NONE, 1'b0);
    txn_case(UEH_M_NAKIN_ST, UEH_TK_OUT, 6'h02, 3'h6,
      8'h3E, UEH_R_ACK, 1'b1);
    txn_case(UEH_M_NAKIN_ST, UEH_TK_OUT, 6'h03, 3'h6,
      8'h23, UEH_R_STALL, 1'b1);
    txn_case(UEH_M_STATOUT, UEH_TK_OUT, 6'h02, 3'h4,
      8'h23, UEH_R_STALL, 1'b1);
    $display("test modes done");
    // Accepted setup also marks the handshake phase done
    txn_case(UEH_M_IN_ST, UEH_TK_SETUP, 6'h0A, 3'h6,
      8'h91, UEH_R_ACK, 1'b1);
    reg_wr(UEH_ADDR_MODE, {4'h0, UEH_M_IN_ST});
    reg_rd(UEH_ADDR_MODE, v);
    check("setup_hold", v, 8'h8F);
    txn_case(UEH_M_IN_ST, UEH_TK_OUT, 6'h02, 3'h6,
      8'hBE, UEH_R_ACK, 1'b1);
    reg_wr(UEH_ADDR_MODE, 8'h0E);
    reg_rd(UEH_ADDR_MODE, v);
    check("setup_free", v, 8'h0E);
    $display("test setup done");
    end_of_test();
  end
endmodule : ueh_sie_tb_top
